// File: mclkg_top.sv
// master clock generator: axi4-lite registers, prescalers, loop model, cpu and system enables
module mclkg_top
   import mclkg_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic osc_i,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic master_clk_en_o,
   output logic cpu_clk_en_o,
   output logic ebc_clk_en_o,
   output logic sys_clk_en_o,
   output logic cpu_clk_o,
   output logic loop_enable_o,
   output logic [1:0] vco_band_o
);
   logic osc_s1;
   logic osc_s2;
   logic osc_s3;
   logic osc_edge;
   logic [1:0] master_clock_source_select;
   logic [1:0] input_prescaler_value;
   logic [3:0] output_prescaler_value;
   logic [4:0] feedback_multiplier_value;
   logic [1:0] vco_band_select;
   logic cpu_clock_halve_select;
   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [7:0] loop_mul_now;
   logic [7:0] slew_cnt;
   logic loop_locked;
   logic in_pulse;
   logic vco_pulse;
   logic vco_en;
   logic [7:0] vco_acc;
   logic [7:0] next_vco_acc;
   logic halve_live;
   logic half_phase;
   mclkg_mode_type mode;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i]) r[8*i +: 8] = d[8*i +: 8];
      end
      return r;
   endfunction : merge

   // oscillator sampled by three flip-flops; the rising edge is taken from the last two
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
      end
      else
      begin
         osc_s1 <= osc_i;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
      end
   end
   assign osc_edge = osc_s2 && !osc_s3;

   // write channel: address and data taken in either order
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= MCLKG_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == MCLKG_CFG_ADDR || aw_addr == MCLKG_SYS1_ADDR ||
                            aw_addr == MCLKG_STAT_ADDR) ? MCLKG_RESP_OKAY : MCLKG_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // configuration fields; prescalers saturate at their documented maxima
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         master_clock_source_select <= MCLKG_CFG_RESET[MCLKG_SRC_LSB +: 2];
         input_prescaler_value <= MCLKG_CFG_RESET[MCLKG_IDIV_LSB +: 2];
         output_prescaler_value <= MCLKG_CFG_RESET[MCLKG_ODIV_LSB +: 4];
         feedback_multiplier_value <= MCLKG_CFG_RESET[MCLKG_MUL_LSB +: 5];
         vco_band_select <= MCLKG_CFG_RESET[MCLKG_VB_LSB +: 2];
         cpu_clock_halve_select <= 1'b0;
      end
      else if (do_write && aw_addr == MCLKG_CFG_ADDR)
      begin
         logic [31:0] v;
         v = merge({14'h0, vco_band_select, 3'h0, feedback_multiplier_value,
                    output_prescaler_value, input_prescaler_value,
                    master_clock_source_select}, w_data, w_strb);
         master_clock_source_select <= v[MCLKG_SRC_LSB +: 2];
         input_prescaler_value <= v[MCLKG_IDIV_LSB +: 2];
         output_prescaler_value <= (v[MCLKG_ODIV_LSB +: 4] > MCLKG_ODIV_MAX) ?
                                   MCLKG_ODIV_MAX : v[MCLKG_ODIV_LSB +: 4];
         feedback_multiplier_value <= v[MCLKG_MUL_LSB +: 5];
         if (v[MCLKG_VB_LSB +: 2] != MCLKG_VB_RSVD)
         begin
            vco_band_select <= v[MCLKG_VB_LSB +: 2];
         end
      end
      else if (do_write && aw_addr == MCLKG_SYS1_ADDR && w_strb[0])
      begin
         cpu_clock_halve_select <= w_data[MCLKG_HALVE_BIT];
      end
   end

   // only 11 selects the loop; 00, 01 and 10 stay in bypass
   assign mode = (master_clock_source_select == MCLKG_SRC_LOOP) ?
                 MCLKG_MODE_LOOP : MCLKG_MODE_BYPASS;
   assign loop_enable_o = (mode == MCLKG_MODE_LOOP);
   assign vco_band_o = vco_band_select;

   // input prescaler runs on oscillator edges in both modes
   mclkg_divider #(.W(2)) u_in_div
   (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .en_i(osc_edge),
      .div_i(input_prescaler_value),
      .pulse_o(in_pulse)
   );

   // loop model: multiplier slews one step per interval toward its target
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         loop_mul_now <= 8'h01;
         slew_cnt <= '0;
      end
      else if (mode != MCLKG_MODE_LOOP)
      begin
         loop_mul_now <= 8'h01;
         slew_cnt <= '0;
      end
      else if (slew_cnt == MCLKG_SLEW_CYCLES)
      begin
         slew_cnt <= '0;
         if (loop_mul_now < {3'h0, feedback_multiplier_value} + 8'h01)
            loop_mul_now <= loop_mul_now + 8'h01;
         else if (loop_mul_now > {3'h0, feedback_multiplier_value} + 8'h01)
            loop_mul_now <= loop_mul_now - 8'h01;
      end
      else
      begin
         slew_cnt <= slew_cnt + 8'h01;
      end
   end
   assign loop_locked = (loop_mul_now == {3'h0, feedback_multiplier_value} + 8'h01);

   // vco rate: accumulate multiplier per reference pulse, emit up to one pulse a cycle
   always_comb
   begin
      next_vco_acc = vco_acc;
      if (in_pulse) next_vco_acc = next_vco_acc + loop_mul_now;
      vco_en = (next_vco_acc != 8'h00);
      if (vco_en) next_vco_acc = next_vco_acc - 8'h01;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i) vco_acc <= '0;
      else if (mode != MCLKG_MODE_LOOP) vco_acc <= '0;
      else vco_acc <= next_vco_acc;
   end

   assign vco_pulse = (mode == MCLKG_MODE_LOOP) ? vco_en : in_pulse;

   // output prescaler: vco or bypass stream divided by odiv+1
   mclkg_divider #(.W(4)) u_out_div
   (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .en_i(vco_pulse),
      .div_i(output_prescaler_value),
      .pulse_o(master_clk_en_o)
   );

   // halving: select changes only at a master edge with even phase
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         halve_live <= 1'b0;
         half_phase <= 1'b0;
         cpu_clk_o <= 1'b0;
      end
      else if (master_clk_en_o)
      begin
         if (!half_phase) halve_live <= cpu_clock_halve_select;
         half_phase <= !half_phase;
         cpu_clk_o <= (halve_live && half_phase) ? cpu_clk_o : !cpu_clk_o;
      end
   end

   assign cpu_clk_en_o = master_clk_en_o && (!halve_live || half_phase);
   assign ebc_clk_en_o = cpu_clk_en_o;
   assign sys_clk_en_o = cpu_clk_en_o;

   // read channel
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= MCLKG_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= MCLKG_RESP_OKAY;
         unique case (s_axi_araddr)
            MCLKG_CFG_ADDR: s_axi_rdata <= {14'h0, vco_band_select, 3'h0,
                                            feedback_multiplier_value, output_prescaler_value,
                                            input_prescaler_value, master_clock_source_select};
            MCLKG_SYS1_ADDR: s_axi_rdata <= {31'h0, cpu_clock_halve_select};
            MCLKG_STAT_ADDR: s_axi_rdata <= {22'h0, loop_mul_now, halve_live, loop_locked};
            default:
            begin
               s_axi_rdata <= '0;
               s_axi_rresp <= MCLKG_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
endmodule : mclkg_top

// File: mclkg_pkg.sv
// package: register map, field layout and reset values of the master clock generator
package mclkg_pkg;
   localparam logic [31:0] MCLKG_CFG_ADDR = 32'h0000_0000;
   localparam logic [31:0] MCLKG_SYS1_ADDR = 32'h0000_0004;
   localparam logic [31:0] MCLKG_STAT_ADDR = 32'h0000_0008;
   localparam int MCLKG_SRC_LSB = 0;
   localparam int MCLKG_IDIV_LSB = 2;
   localparam int MCLKG_ODIV_LSB = 4;
   localparam int MCLKG_MUL_LSB = 8;
   localparam int MCLKG_VB_LSB = 16;
   localparam int MCLKG_HALVE_BIT = 0;
   localparam logic [1:0] MCLKG_IDIV_MAX = 2'h3;
   localparam logic [3:0] MCLKG_ODIV_MAX = 4'he;
   localparam logic [1:0] MCLKG_VB_RSVD = 2'h3;
   localparam logic [1:0] MCLKG_SRC_LOOP = 2'h3;
   localparam logic [31:0] MCLKG_CFG_RESET = 32'h0000_0000;
   localparam logic [1:0] MCLKG_RESP_OKAY = 2'h0;
   localparam logic [1:0] MCLKG_RESP_SLVERR = 2'h2;
   localparam logic [7:0] MCLKG_SLEW_CYCLES = 8'h10;
   typedef enum logic [1:0] {MCLKG_MODE_BYPASS, MCLKG_MODE_LOOP} mclkg_mode_type;
endpackage : mclkg_pkg

// File: mclkg_divider.sv
// divider: enable pulse every (div+1) input enables, division factor changes only at wrap
module mclkg_divider
   import mclkg_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic en_i,
   input wire logic [W-1:0] div_i,
   output logic pulse_o
);
   logic [W-1:0] cnt;
   logic [W-1:0] div_held;

   initial
   begin
      if (W < 1) $error("mclkg_divider: W must be at least 1");
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt <= '0;
         div_held <= '0;
      end
      else if (en_i)
      begin
         if (cnt >= div_held)
         begin
            cnt <= '0;
            div_held <= div_i;
         end
         else
         begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // a pass-through divider follows the input enable directly
   assign pulse_o = en_i && (cnt >= div_held);
endmodule : mclkg_divider

// File: mclkg_properties.sv
// checker: port-level properties of the master clock generator
module mclkg_properties
   import mclkg_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic master_clk_en_o,
   input wire logic cpu_clk_en_o,
   input wire logic ebc_clk_en_o,
   input wire logic sys_clk_en_o,
   input wire logic cpu_clk_o,
   input wire logic loop_enable_o,
   input wire logic [1:0] vco_band_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [1:0] src;
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // shadow of the source-select field
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
         src <= 2'h0;
      else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
               s_axi_awaddr == MCLKG_CFG_ADDR && s_axi_wstrb[0])
         src <= s_axi_wdata[1:0];
   a_ebc_tracks_cpu: assert property (ebc_clk_en_o == cpu_clk_en_o)
      else $error("ebc enable differs from cpu enable");
   a_sys_tracks_cpu: assert property (sys_clk_en_o == cpu_clk_en_o)
      else $error("system enable differs from cpu enable");
   a_cpu_in_master: assert property (cpu_clk_en_o |-> master_clk_en_o)
      else $error("cpu pulse outside a master pulse");
   a_band_not_rsvd: assert property (vco_band_o != MCLKG_VB_RSVD)
      else $error("reserved vco band driven");
   a_loop_by_src: assert property (s_axi_bvalid |-> loop_enable_o == (src == MCLKG_SRC_LOOP))
      else $error("loop enable does not match source select");
   a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken during answer");
   a_cpu_clk_edge: assert property ($changed(cpu_clk_o) |-> $past(master_clk_en_o))
      else $error("cpu clock level changed outside a master pulse");
endmodule : mclkg_properties
bind mclkg_top mclkg_properties u_props (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .master_clk_en_o(master_clk_en_o), .cpu_clk_en_o(cpu_clk_en_o),
   .ebc_clk_en_o(ebc_clk_en_o), .sys_clk_en_o(sys_clk_en_o), .cpu_clk_o(cpu_clk_o),
   .loop_enable_o(loop_enable_o),
   .vco_band_o(vco_band_o));

// File: mclkg_osc_model.sv
// oscillator model: free-running input clock, phase unrelated to the system clock
module mclkg_osc_model
#(
   parameter real HALF_NS = 36.5
)
(
   output logic osc_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      osc_o = 1'b0;
      #3.3;
      forever #(HALF_NS) osc_o = ~osc_o;
   end
endmodule : mclkg_osc_model

// File: tb.sv
// testbench: register access, bypass and loop ratios, cpu halving
module tb;
   import mclkg_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam real OSC_NS = 73.0;
   logic clk_i, arst_n_i, osc_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic master_clk_en_o, cpu_clk_en_o, ebc_clk_en_o, sys_clk_en_o, cpu_clk_o, loop_enable_o;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb, ov;
   logic [1:0] s_axi_bresp, s_axi_rresp, vco_band_o, rsp, iv;
   logic [7:0] prev;
   int n_errors, n_tests;
   real per;
   mclkg_osc_model #(.HALF_NS(OSC_NS / 2.0)) osc (.osc_o(osc_i));
   mclkg_top uut (.*);
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic chk_near(input string nm, input real exp, input real got);
      n_tests++;
      if (got < exp - 10.0 || got > exp + 10.0)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %f seen %f", nm, exp, got);
      end
   endtask : chk_near
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_i);
   endtask : axi_wr
   task automatic axi_rd(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_i);
   endtask : axi_rd
   // mean of four spacings between five enable pulses, after two settling pulses
   task automatic period(input bit cpu);
      real t0;
      int k;
      k = -2;
      t0 = 0.0;
      while (k < 5)
      begin
         @(posedge clk_i);
         if ((cpu ? cpu_clk_en_o : master_clk_en_o) === 1'b1)
         begin
            if (k == 0) t0 = $realtime;
            k++;
         end
      end
      per = ($realtime - t0) / 4.0;
   endtask : period
   task automatic final_report;
      $display("compares %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      #900000;
      n_errors++;
      final_report;
   end
   initial
   begin
      {arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      void'($urandom(26));
      axi_rd(MCLKG_CFG_ADDR);
      chk("cfg reset", MCLKG_CFG_RESET, rdat);
      axi_rd(32'h0000_0010);
      chk("unmapped resp", 32'(MCLKG_RESP_SLVERR), 32'(rsp));
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         iv = (i < 2) ? 2'(i * 3) : 2'($urandom % 4);
         ov = (i < 2) ? 4'(i * 14) : 4'($urandom % 15);
         axi_wr(MCLKG_CFG_ADDR, {24'h0, ov, iv, 2'(i % 3)});
         chk("loop off", 32'h0, 32'(loop_enable_o));
         period(1'b0);
         chk_near("bypass period", OSC_NS * (iv + 1) * (ov + 1), per);
      end
      axi_wr(MCLKG_CFG_ADDR, 32'h0000_00f0);
      chk("write resp", 32'(MCLKG_RESP_OKAY), 32'(rsp));
      axi_rd(MCLKG_CFG_ADDR);
      chk("odiv ceiling", 32'(MCLKG_ODIV_MAX), 32'(rdat[7:4]));
      $display("test bypass done");
      for (int b = 0; b < 4; b++)
      begin
         axi_wr(MCLKG_CFG_ADDR, 32'(b) << MCLKG_VB_LSB);
         chk("vco band", 32'((b == 3) ? 2 : b), 32'(vco_band_o));
      end
      $display("test band done");
      prev = 8'h1;
      axi_wr(MCLKG_CFG_ADDR, 32'h0000_0333);
      chk("loop on", 32'h1, 32'(loop_enable_o));
      for (int i = 0; i < 40; i++)
      begin
         axi_rd(MCLKG_STAT_ADDR);
         chk("slew step", 32'h1, 32'(rdat[9:2] <= prev + 8'h1));
         prev = rdat[9:2];
      end
      chk("loop mult", 32'h4, 32'(rdat[9:2]));
      period(1'b0);
      chk_near("loop period", OSC_NS, per);
      axi_wr(MCLKG_CFG_ADDR, 32'h0000_0313);
      period(1'b0);
      chk_near("loop odiv", OSC_NS / 2.0, per);
      $display("test loop done");
      axi_wr(MCLKG_CFG_ADDR, 32'h0000_0010);
      axi_wr(MCLKG_SYS1_ADDR, 32'h0000_0001);
      period(1'b1);
      chk_near("halved cpu", OSC_NS * 4.0, per);
      period(1'b0);
      chk_near("master kept", OSC_NS * 2.0, per);
      axi_wr(MCLKG_SYS1_ADDR, 32'h0000_0000);
      period(1'b1);
      chk_near("full cpu", OSC_NS * 2.0, per);
      $display("test halve done");
      final_report;
   end
endmodule : tb
